// ---- core/sptim_regs.vh ----
// Purpose: Register map, field positions and reset values of the split timer
// Assumes: 32-bit register port, word aligned byte offsets
// Notes:   Overview list below, tags used in code
//
// Overview of operation
// R01 - Codes 100-111 pick pins 4-7 or triggers
// R02 - Codes 000-011 pick pins 0-3 or triggers
// R03 - Edge field chooses pin versus companion trigger for count, capture 0, capture 1
// R04 - Upper selector used only in split mode
// R05 - Upper selector fields at 4-bit steps
// R06 - Reserved bits read zero, writes dropped
// R07 - Edge codes: trigger, rise, fall, both
// R08 - Lower edge fields at bits 1:0..13:12
// R09 - Upper edge fields at bits 17:16..29:28
// R10 - Both halves have identical mode controls
// R11 - Lower mode fields at bits 1:0..8
// R12 - Upper mode fields at bits 17:16..24
// R13 - One-shot stops half after first wrap
// R14 - Direction flag: 0 up, 1 down
// R15 - Split bit selects 32-bit or two halves
// R16 - Overflow threshold FFFF->0 or FFFE->FFFF
// R17 - Underflow threshold 0->FFFF or 1->0
// R18 - Clear code 00 clears on clear event
// R19 - Clear code 01 clears on capture 0
// R20 - Clear code 10 on capture 1, capture first
// R21 - Direction control: sw or input level
// R22 - Count source: clock, input, quadrature
// R23 - Edges sampled, pulses act next cycle
// R24 - 32-bit mode carries across halves
`ifndef SPTIM_REGS_VH
`define SPTIM_REGS_VH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define SPTIM_LO_SEL_OFS   8'h00
`define SPTIM_UP_SEL_OFS   8'h04
`define SPTIM_EDGE_OFS     8'h08
`define SPTIM_MODE_OFS     8'h0c
`define SPTIM_RUN_OFS      8'h10
`define SPTIM_COUNT_OFS    8'h14
`define SPTIM_CAP0_OFS     8'h18
`define SPTIM_CAP1_OFS     8'h1c

// ----------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------
`define SPTIM_SEL_MASK     32'h07777777
`define SPTIM_EDGE_MASK    32'h3fff3fff
`define SPTIM_MODE_MASK    32'h01ff81ff
`define SPTIM_REG_RST      32'h00000000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SPTIM_HALF_STEP    16
`define SPTIM_SEL_STEP     4
`define SPTIM_EDGE_STEP    2
`define SPTIM_CSRC_POS     0
`define SPTIM_CDIR_POS     2
`define SPTIM_CCLR_POS     4
`define SPTIM_COV_POS      6
`define SPTIM_COS_POS      8
`define SPTIM_DIR_POS      12
`define SPTIM_SPLIT_POS    15

// ----------------------------------------------------------------
// Function indices and codes
// ----------------------------------------------------------------
`define SPTIM_FN_CNT       0
`define SPTIM_FN_STR       1
`define SPTIM_FN_STP       2
`define SPTIM_FN_UD        3
`define SPTIM_FN_CLR       4
`define SPTIM_FN_RC0       5
`define SPTIM_FN_RC1       6
`define SPTIM_NUM_FN       7
`define SPTIM_EDGE_TRG     2'b00
`define SPTIM_EDGE_RISE    2'b01
`define SPTIM_EDGE_FALL    2'b10
`define SPTIM_EDGE_BOTH    2'b11
`define SPTIM_SRC_CLK      2'b00
`define SPTIM_SRC_EXT      2'b01
`define SPTIM_SRC_QUAD     2'b10
`define SPTIM_DIR_UP       2'b00
`define SPTIM_DIR_DOWN     2'b01
`define SPTIM_DIR_HI_UP    2'b10
`define SPTIM_CLR_EXT      2'b00
`define SPTIM_CLR_CAP0     2'b01
`define SPTIM_CLR_CAP1     2'b10

`endif

// ---- core/sptim_evt.v ----
// Purpose: Input select and edge detect for one timer function
// Assumes: Pin samples already synchronised
// Notes:   Combinational, the caller registers the pulse

`include "sptim_regs.vh"

module sptim_evt #(
    parameter TRG_OK = 0
) (
    input  wire [7:0] pin_s,
    input  wire [7:0] pin_p,
    input  wire [3:0] trg,
    input  wire [2:0] sel,
    input  wire [1:0] edg,
    output reg        evt,
    output wire       lvl,
    output wire       lvp
);

    // ----------------------------------------------------------------
    // Selection
    // ----------------------------------------------------------------
    assign lvl = pin_s[sel]; // R01 R02
    assign lvp = pin_p[sel];

    // ----------------------------------------------------------------
    // Edge decode
    // ----------------------------------------------------------------
    always @* begin
        case (edg) // R07
            `SPTIM_EDGE_TRG: evt = (TRG_OK != 0) & trg[sel[1:0]]; // R03
            `SPTIM_EDGE_RISE: evt = lvl & ~lvp;
            `SPTIM_EDGE_FALL: evt = ~lvl & lvp;
            `SPTIM_EDGE_BOTH: evt = lvl ^ lvp;
            default: evt = 1'b0;
        endcase
    end

endmodule

// ---- core/sptim_top.v ----
// Purpose: Input, edge and mode control of a 32-bit or split timer
// Assumes: Register port on ref_clk, pins asynchronous
// Notes:   Triggers come from logic on ref_clk
//
// Design decisions made here: strobed register access and the address map.

`include "sptim_regs.vh"

module sptim_top (
    input  wire        ref_clk,
    input  wire        nrst,
    input  wire [7:0]  addr,
    input  wire [31:0] wr_data,
    input  wire        wr_en,
    input  wire        rd_en,
    output reg  [31:0] rd_data,
    input  wire [7:0]  pin_in,
    input  wire [3:0]  companion_trigger,
    output reg         lower_wrap,
    output reg         upper_wrap,
    output reg         lower_run,
    output reg         upper_run
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg  [31:0] lower_half_input_select_r;
    reg  [31:0] upper_half_input_select_r;
    reg  [31:0] input_edge_select_r;
    reg  [31:0] mode_r;
    reg  [1:0]  dir_r;
    reg  [31:0] cnt_r;
    reg  [31:0] cnt_nxt;
    reg  [31:0] cap0_r;
    reg  [31:0] cap1_r;
    reg  [1:0]  run_r;
    reg  [1:0]  run_nxt;
    reg  [1:0]  wrap_nxt;
    reg  [7:0]  pin_s1_r;
    reg  [7:0]  pin_s2_r;
    reg  [7:0]  pin_p_r;
    reg  [13:0] ev_r;
    reg  [1:0]  qstep_r;
    reg  [1:0]  qup_r;
    reg  [33:0] res_lo;
    reg  [33:0] res_hi;
    reg  [33:0] res_w;
    reg  [31:0] rd_nxt;

    wire        split_enable = mode_r[`SPTIM_SPLIT_POS];
    wire [13:0] ev;
    wire [13:0] lv;
    wire [13:0] lp;
    wire [1:0]  step;
    wire [1:0]  up;
    wire [1:0]  clr;
    wire [1:0]  cos;

    wire        wr_run = wr_en & (addr == `SPTIM_RUN_OFS);

    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_r <= 8'h00;
            pin_s2_r <= 8'h00;
            pin_p_r  <= 8'h00;
        end else begin
            pin_s1_r <= pin_in;
            pin_s2_r <= pin_s1_r;
            pin_p_r  <= pin_s2_r; // R23
        end
    end

    // ----------------------------------------------------------------
    // Function inputs
    // ----------------------------------------------------------------
    genvar f;
    generate
        for (f = 0; f < 2 * `SPTIM_NUM_FN; f = f + 1) begin : g_fn
            localparam H  = f / `SPTIM_NUM_FN;
            localparam FN = f % `SPTIM_NUM_FN;
            localparam TO = (FN == `SPTIM_FN_CNT) || (FN == `SPTIM_FN_RC0)
                            || (FN == `SPTIM_FN_RC1);
            wire [31:0] sel_reg = (H == 1 && split_enable) ?
                upper_half_input_select_r : lower_half_input_select_r; // R04
            sptim_evt #(
                .TRG_OK (TO ? 1 : 0)
            ) u_evt (
                .pin_s (pin_s2_r),
                .pin_p (pin_p_r),
                .trg   (companion_trigger),
                .sel   (sel_reg[FN*`SPTIM_SEL_STEP +: 3]), // R05
                .edg   (input_edge_select_r[H*`SPTIM_HALF_STEP
                        + FN*`SPTIM_EDGE_STEP +: 2]), // R08 R09
                .evt   (ev[f]),
                .lvl   (lv[f]),
                .lvp   (lp[f])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Event registers
    // ----------------------------------------------------------------
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ev_r    <= 14'h0000;
            qstep_r <= 2'b00;
            qup_r   <= 2'b00;
        end else begin
            ev_r    <= ev; // R23
            qstep_r <= {(lv[7] ^ lp[7]) | (lv[10] ^ lp[10]),
                        (lv[0] ^ lp[0]) | (lv[3] ^ lp[3])};
            qup_r   <= {lv[7] ^ lp[10], lv[0] ^ lp[3]};
        end
    end

    // ----------------------------------------------------------------
    // Per-half controls
    // ----------------------------------------------------------------
    genvar h;
    generate
        for (h = 0; h < 2; h = h + 1) begin : g_half // R10
            localparam B = h * `SPTIM_HALF_STEP;
            localparam E = h * `SPTIM_NUM_FN;
            wire [1:0] csrc = mode_r[B + `SPTIM_CSRC_POS +: 2];
            wire [1:0] cdir = mode_r[B + `SPTIM_CDIR_POS +: 2];
            wire [1:0] cclr = mode_r[B + `SPTIM_CCLR_POS +: 2];
            wire       udl  = lv[E + `SPTIM_FN_UD];
            assign step[h] = run_r[h] & (
                (csrc == `SPTIM_SRC_CLK) |
                ((csrc == `SPTIM_SRC_EXT) & ev_r[E + `SPTIM_FN_CNT]) |
                ((csrc == `SPTIM_SRC_QUAD) & qstep_r[h])); // R22
            assign up[h] = (csrc == `SPTIM_SRC_QUAD) ? qup_r[h] :
                (cdir == `SPTIM_DIR_UP) ? 1'b1 :
                (cdir == `SPTIM_DIR_DOWN) ? 1'b0 :
                (cdir == `SPTIM_DIR_HI_UP) ? udl : ~udl; // R21
            assign clr[h] =
                ((cclr == `SPTIM_CLR_EXT) & ev_r[E + `SPTIM_FN_CLR]) | // R18
                ((cclr == `SPTIM_CLR_CAP0) & ev_r[E + `SPTIM_FN_RC0]) | // R19
                ((cclr == `SPTIM_CLR_CAP1) & ev_r[E + `SPTIM_FN_RC1]); // R20
            assign cos[h] = mode_r[B + `SPTIM_COS_POS]; // R13
        end
    endgenerate

    // ----------------------------------------------------------------
    // Count step: returns {ovf, unf, next}
    // ----------------------------------------------------------------
    function [33:0] sptim_calc;
        input [31:0] v;
        input [31:0] mx;
        input        st;
        input        dn_up;
        input        cl;
        input [1:0]  cov;
        reg          ovf;
        reg          unf;
        reg   [31:0] nx;
        begin
            ovf = st & dn_up & (cov[0] ? (v == mx - 32'h00000001)
                                       : (v == mx)); // R16
            unf = st & ~dn_up & (cov[1] ? (v == 32'h00000001)
                                        : (v == 32'h00000000)); // R17
            nx  = st ? (dn_up ? v + 32'h00000001 : v - 32'h00000001) : v;
            if (cl) begin
                ovf = 1'b0;
                unf = 1'b0;
                nx  = 32'h00000000;
            end
            sptim_calc = {ovf, unf, nx & mx};
        end
    endfunction

    // ----------------------------------------------------------------
    // Counter next state
    // ----------------------------------------------------------------
    always @* begin
        res_lo = sptim_calc({16'h0000, cnt_r[15:0]}, 32'h0000ffff,
                            step[0], up[0], clr[0],
                            mode_r[`SPTIM_COV_POS +: 2]);
        res_hi = sptim_calc({16'h0000, cnt_r[31:16]}, 32'h0000ffff,
                            step[1], up[1], clr[1],
                            mode_r[`SPTIM_HALF_STEP + `SPTIM_COV_POS +: 2]);
        res_w  = sptim_calc(cnt_r, 32'hffffffff, step[0], up[0], clr[0],
                            mode_r[`SPTIM_COV_POS +: 2]); // R24
        if (split_enable) begin // R15
            cnt_nxt  = {res_hi[15:0], res_lo[15:0]};
            wrap_nxt = {res_hi[33] | res_hi[32], res_lo[33] | res_lo[32]};
        end else begin
            cnt_nxt  = res_w[31:0];
            wrap_nxt = {1'b0, res_w[33] | res_w[32]};
        end
        run_nxt = run_r;
        if (ev_r[`SPTIM_FN_STR])
            run_nxt[0] = 1'b1;
        if (ev_r[`SPTIM_NUM_FN + `SPTIM_FN_STR])
            run_nxt[1] = 1'b1;
        if (ev_r[`SPTIM_FN_STP])
            run_nxt[0] = 1'b0;
        if (ev_r[`SPTIM_NUM_FN + `SPTIM_FN_STP])
            run_nxt[1] = 1'b0;
        run_nxt = run_nxt & ~(wrap_nxt & cos); // R13
        if (wr_run) begin
            if (wr_data[0] & ~wr_data[1])
                run_nxt[0] = 1'b1;
            if (wr_data[1] & ~wr_data[0])
                run_nxt[0] = 1'b0;
            if (wr_data[2] & ~wr_data[3])
                run_nxt[1] = 1'b1;
            if (wr_data[3] & ~wr_data[2])
                run_nxt[1] = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Counter, capture, run and direction state
    // ----------------------------------------------------------------
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r  <= `SPTIM_REG_RST;
            cap0_r <= `SPTIM_REG_RST;
            cap1_r <= `SPTIM_REG_RST;
            run_r  <= 2'b00;
            dir_r  <= 2'b00;
        end else begin
            if (wr_en && addr == `SPTIM_COUNT_OFS)
                cnt_r <= wr_data;
            else
                cnt_r <= cnt_nxt;
            if (split_enable) begin
                if (ev_r[`SPTIM_FN_RC0])
                    cap0_r[15:0] <= cnt_r[15:0]; // R20
                if (ev_r[`SPTIM_FN_RC1])
                    cap1_r[15:0] <= cnt_r[15:0];
                if (ev_r[`SPTIM_NUM_FN + `SPTIM_FN_RC0])
                    cap0_r[31:16] <= cnt_r[31:16];
                if (ev_r[`SPTIM_NUM_FN + `SPTIM_FN_RC1])
                    cap1_r[31:16] <= cnt_r[31:16];
            end else begin
                if (ev_r[`SPTIM_FN_RC0])
                    cap0_r <= cnt_r;
                if (ev_r[`SPTIM_FN_RC1])
                    cap1_r <= cnt_r;
            end
            run_r <= run_nxt;
            dir_r <= ~up; // R14
        end
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lower_half_input_select_r <= `SPTIM_REG_RST;
            upper_half_input_select_r <= `SPTIM_REG_RST;
            input_edge_select_r       <= `SPTIM_REG_RST;
            mode_r                    <= `SPTIM_REG_RST;
        end else if (wr_en) begin
            case (addr) // R06
                `SPTIM_LO_SEL_OFS:
                    lower_half_input_select_r <= wr_data & `SPTIM_SEL_MASK;
                `SPTIM_UP_SEL_OFS:
                    upper_half_input_select_r <= wr_data & `SPTIM_SEL_MASK;
                `SPTIM_EDGE_OFS:
                    input_edge_select_r <= wr_data & `SPTIM_EDGE_MASK;
                `SPTIM_MODE_OFS:
                    mode_r <= wr_data & `SPTIM_MODE_MASK; // R11 R12
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always @* begin
        case (addr)
            `SPTIM_LO_SEL_OFS: rd_nxt = lower_half_input_select_r;
            `SPTIM_UP_SEL_OFS: rd_nxt = upper_half_input_select_r;
            `SPTIM_EDGE_OFS:   rd_nxt = input_edge_select_r;
            `SPTIM_MODE_OFS: begin
                rd_nxt = mode_r;
                rd_nxt[`SPTIM_DIR_POS] = dir_r[0]; // R14
                rd_nxt[`SPTIM_HALF_STEP + `SPTIM_DIR_POS] = dir_r[1];
            end
            `SPTIM_RUN_OFS:    rd_nxt = {30'h0, run_r};
            `SPTIM_COUNT_OFS:  rd_nxt = cnt_r;
            `SPTIM_CAP0_OFS:   rd_nxt = cap0_r;
            `SPTIM_CAP1_OFS:   rd_nxt = cap1_r;
            default:           rd_nxt = 32'h00000000;
        endcase
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rd_data    <= 32'h00000000;
            lower_wrap <= 1'b0;
            upper_wrap <= 1'b0;
            lower_run  <= 1'b0;
            upper_run  <= 1'b0;
        end else begin
            rd_data    <= rd_en ? rd_nxt : 32'h00000000;
            lower_wrap <= wrap_nxt[0];
            upper_wrap <= wrap_nxt[1];
            lower_run  <= run_nxt[0];
            upper_run  <= run_nxt[1];
        end
    end

endmodule

// ---- verif/sptim_chk.sv ----
// Purpose: Port-level checks of the split timer
// Assumes: Mode register shadowed from bus writes
// Notes:   Bound to sptim_top at the foot of this file
module sptim_chk (
    input wire        ref_clk,
    input wire        nrst,
    input wire [7:0]  addr,
    input wire [31:0] wr_data,
    input wire        wr_en,
    input wire        rd_en,
    input wire [31:0] rd_data,
    input wire [7:0]  pin_in,
    input wire [3:0]  companion_trigger,
    input wire        lower_wrap,
    input wire        upper_wrap,
    input wire        lower_run,
    input wire        upper_run
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [31:0] mode_r;
    reg [1:0]  age_r;

    // ----------------------------------------------------------------
    // Shadow of the mode register and cycles since its last write
    // ----------------------------------------------------------------
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mode_r <= 32'h0;
            age_r  <= 2'h0;
        end else if (wr_en && addr == 8'h0c) begin
            mode_r <= wr_data;
            age_r  <= 2'h0;
        end else if (age_r != 2'h3) begin
            age_r <= age_r + 2'h1;
        end
    end

    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    a_unmapped_zero: assert property (
        rd_en && addr >= 8'h20 |=> rd_data == 32'h0) else $error("bad read");
    a_sel_rsvd: assert property (
        rd_en && addr[7:3] == 5'h0 |=> (rd_data & 32'hf8888888) == 32'h0)
        else $error("selector reserved bit set");
    a_edge_rsvd: assert property (
        rd_en && addr == 8'h08 |=> rd_data[15:14] == 2'h0
        && rd_data[31:30] == 2'h0) else $error("edge reserved bit set");
    a_mode_rsvd: assert property (
        rd_en && addr == 8'h0c |=> (rd_data & 32'hee006e00) == 32'h0)
        else $error("mode reserved bit set");
    a_upper_split: assert property (
        upper_wrap |-> mode_r[15]) else $error("upper wrap unsplit");
    a_wrap_run: assert property (
        lower_wrap |-> $past(lower_run)) else $error("wrap while stopped");
    a_lower_oneshot: assert property (
        lower_wrap && mode_r[8] |-> !lower_run) else $error("no stop");
    a_upper_oneshot: assert property (
        upper_wrap && mode_r[24] |-> !upper_run) else $error("no stop");
    a_flag_down: assert property (
        rd_en && addr == 8'h0c && age_r == 2'h3 && mode_r[3:0] == 4'h4
        |=> rd_data[12]) else $error("flag not down");
    a_flag_up: assert property (
        rd_en && addr == 8'h0c && age_r == 2'h3 && mode_r[3:0] == 4'h0
        |=> !rd_data[12]) else $error("flag not up");
endmodule

bind sptim_top sptim_chk i_chk (
    .ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .pin_in(pin_in),
    .companion_trigger(companion_trigger), .lower_wrap(lower_wrap),
    .upper_wrap(upper_wrap), .lower_run(lower_run), .upper_run(upper_run)
);

// ---- verif/sptim_far.sv ----
// Purpose: Pins and companion triggers seen by the split timer
// Assumes: Changes just after rising edges of ref_clk
// Notes:   Pin levels held 4 cycles so the sync stages see them
module sptim_far (
    input  wire        ref_clk,
    output logic [7:0] pin_in,
    output logic [3:0] companion_trigger
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        pin_in = 8'h00;
        companion_trigger = 4'h0;
    end
    task set_pin(input int p, input logic v);
        @(posedge ref_clk);
        pin_in[p] <= v;
    endtask
    // Pin pulse or one-cycle trigger pulse, repeated n times
    task pulse(input int p, input int n, input logic t);
        repeat (n) begin
            @(posedge ref_clk);
            if (t)
                companion_trigger[p] <= 1'b1;
            else
                pin_in[p] <= 1'b1;
            repeat (t ? 1 : 4) @(posedge ref_clk);
            companion_trigger <= 4'h0;
            if (!t)
                pin_in[p] <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
    endtask
endmodule

// ---- verif/sptim_top_bench.sv ----
// Purpose: Self-checking bench of the split timer
// Assumes: Offsets 0x00..0x1c, run control at 0x10
// Notes:   Read results checked against a queue of notes
module sptim_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk;
    logic        nrst;
    logic [7:0]  addr;
    logic [31:0] wr_data;
    logic        wr_en;
    logic        rd_en;
    wire  [31:0] rd_data;
    wire  [7:0]  pin_in;
    wire  [3:0]  companion_trigger;
    wire         lower_wrap;
    wire         upper_wrap;
    wire         lower_run;
    wire         upper_run;
    logic [63:0] note_q[$];
    logic [63:0] note;
    logic        rd_q;
    int          bad_count;
    int          num_checks;
    int          wraps;
    logic [31:0] md [6] = '{32'h0, 32'h100, 32'h140, 32'h104, 32'h184,
                            32'h1c4};

    sptim_top i_dut (
        .ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .pin_in(pin_in),
        .companion_trigger(companion_trigger), .lower_wrap(lower_wrap),
        .upper_wrap(upper_wrap), .lower_run(lower_run),
        .upper_run(upper_run));
    sptim_far i_far (.ref_clk(ref_clk), .pin_in(pin_in),
        .companion_trigger(companion_trigger));

    always #20 ref_clk = ~ref_clk;

    // ----------------------------------------------------------------
    // Checking and bus tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task bus(input logic [7:0] a, input logic [31:0] d, input logic w);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= w;
        rd_en <= !w;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, d, 1'b1);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        note_q.push_back({e & m, m});
        bus(a, 32'h0, 1'b0);
    endtask
    task wait_wrap(input logic up);
        int w;
        for (w = 0; w < 80; w++) begin
            @(posedge ref_clk);
            if ((up ? upper_wrap : lower_wrap) === 1'b1)
                break;
        end
        if (w == 80) begin
            bad_count++;
            $display("CHECK FAILED at %0t: no wrap", $time);
            wrap_up();
        end
    endtask

    // Read data stand in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (rd_q === 1'b1) begin
            note = note_q.pop_front();
            chk(rd_data & note[31:0], note[63:32]);
        end
        rd_q <= rd_en;
        if (lower_wrap === 1'b1)
            wraps++;
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        int i, k, e, n, r;
        {ref_clk, nrst, wr_en, rd_en} = 4'h0;
        addr = 8'h00;
        wr_data = 32'h0;
        r = $urandom(32'h2cac3f92);
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        for (i = 0; i < 5; i++)
            rd(8'(i * 4), 32'h0, '1);
        wr(8'h00, '1);
        wr(8'h04, '1);
        wr(8'h08, '1);
        wr(8'h0c, 32'hfe04fe04);
        repeat (4) @(posedge ref_clk);
        rd(8'h00, 32'h07777777, '1);
        rd(8'h04, 32'h07777777, '1);
        rd(8'h08, 32'h3fff3fff, '1);
        rd(8'h0c, 32'h10049004, '1);
        rd(8'h20, 32'h0, '1);
        for (i = 0; i < 6; i++) begin
            r = $urandom_range(19, 4);
            wr(8'h0c, md[i]);
            wr(8'h14, i < 3 ? ~32'(r) : 32'(r));
            wr(8'h10, 32'h1);
            wait_wrap(1'b0);
            repeat (2) @(posedge ref_clk);
            chk({31'h0, lower_run}, {31'h0, i == 0});
            rd(8'h14, (i == 2 || i == 3) ? '1 : 32'h0,
               i == 0 ? 32'h0 : 32'hffffffff);
            wr(8'h10, 32'ha);
        end
        wr(8'h0c, 32'h0);
        wr(8'h14, 32'h0000fff0);
        n = wraps;
        wr(8'h10, 32'h1);
        repeat (40) @(posedge ref_clk);
        wr(8'h10, 32'ha);
        chk(32'(wraps - n), 32'h0);
        rd(8'h14, 32'h00010000, 32'hffff0000);
        wr(8'h0c, 32'h01008100);
        wr(8'h14, 32'hfff0fff8);
        wr(8'h10, 32'h5);
        wait_wrap(1'b0);
        wait_wrap(1'b1);
        repeat (2) @(posedge ref_clk);
        chk({30'h0, lower_run, upper_run}, 32'h0);
        rd(8'h14, 32'h0, '1);
        for (k = 0; k < 8; k++)
            for (e = 0; e < 4; e++) begin
                n = $urandom_range(3, 1);
                wr(8'h0c, k % 2 ? 32'h18001 : 32'h1);
                wr(8'h00, 32'(k));
                wr(8'h04, 32'(k ^ 1));
                wr(8'h08, 32'(e * 32'h10001));
                wr(8'h14, 32'h0);
                wr(8'h10, 32'h5);
                if (e == 0)
                    i_far.pulse(k % 4, n, 1'b1);
                else
                    i_far.pulse(k, n, 1'b0);
                i_far.pulse(e == 0 ? k : k ^ 1, 1, 1'b0);
                repeat (4) @(posedge ref_clk);
                rd(8'h14, {16'(k % 2 && e ? 1 + (e == 3) : 0),
                    16'(e == 3 ? 2 * n : n)}, '1);
                wr(8'h10, 32'ha);
            end
        for (i = 0; i < 3; i++) begin
            r = $urandom_range(16'hffff, 1);
            wr(8'h0c, 32'(1 + 16 * i));
            wr(8'h00, i == 0 ? 32'h60000 : 32'h5 << (16 + 4 * i));
            wr(8'h08, 32'h100 << (2 * i));
            wr(8'h14, 32'(r));
            wr(8'h10, 32'h1);
            i_far.pulse(i == 0 ? 6 : 5, 1, 1'b0);
            repeat (4) @(posedge ref_clk);
            wr(8'h10, 32'ha);
            rd(8'h14, 32'h0, '1);
            if (i > 0)
                rd(8'h14 + 8'(i * 4), 32'(r), '1);
        end
        wr(8'h00, 32'h7000);
        for (i = 0; i < 4; i++) begin
            i_far.set_pin(7, i[0]);
            wr(8'h0c, i[1] ? 32'hc : 32'h8);
            repeat (6) @(posedge ref_clk);
            rd(8'h0c, {19'h0, i[1] ~^ i[0], 12'h0}, 32'h1000);
        end
        wr(8'h00, 32'h1000);
        wr(8'h08, 32'h0);
        wr(8'h0c, 32'h2);
        wr(8'h14, 32'h0);
        wr(8'h10, 32'h1);
        for (i = 0; i < 8; i++) begin
            if (i == 4)
                wr(8'h0c, 32'h6);
            i_far.set_pin(i % 2, !i[1]);
            repeat (4) @(posedge ref_clk);
            if (i % 4 == 3)
                rd(8'h14, 32'(i + 1), '1);
        end
        repeat (2) @(posedge ref_clk);
        wrap_up();
    end
endmodule
